// ==== hdl/oag_defs.vh ====
// constants for the operand address generator
`ifndef OAG_DEFS_VH
`define OAG_DEFS_VH
// addressing modes
`define AM_REG        3'h0
`define AM_IMM        3'h1
`define AM_DIRECT     3'h2
`define AM_REG_IND    3'h3
`define AM_BASED      3'h4
`define AM_INDEXED    3'h5
`define AM_BASED_IDX  3'h6
`define AM_BIDX_DISP  3'h7
// request kinds
`define KIND_FETCH    3'h0
`define KIND_DATA     3'h1
`define KIND_STACK    3'h2
`define KIND_STRING   3'h3
`define KIND_IO       3'h4
`define KIND_INT      3'h5
// segment codes
`define SEG_ES        2'h0
`define SEG_CS        2'h1
`define SEG_SS        2'h2
`define SEG_DS        2'h3
// base / index selectors
`define BASE_GBR      1'h0
`define BASE_BP       1'h1
`define IDX_SI        1'h0
`define IDX_DI        1'h1
// interrupt sources
`define INT_SRC_HW    2'h0
`define INT_SRC_SW    2'h1
`define INT_SRC_EXC   2'h2
// reserved port window
`define IO_RSV_LO     16'h00f8
`define IO_RSV_HI     16'h00ff
// string length limit in bytes
`define STR_MAX_BYTES 17'h10000
// interrupt push sequence length
`define INT_PUSHES    2'h3
`endif

// ==== hdl/offset_adder.v ====
// three-term offset adder with 8-bit displacement sign extension
`timescale 1ns/1ps
module offset_adder (
    input  wire [15:0] base_val,    // base term, zero when unused
    input  wire [15:0] index_val,   // index term, zero when unused
    input  wire [15:0] disp_raw,    // displacement as carried
    input  wire        disp_wide,   // displacement is 16 bits
    input  wire        disp_use,    // displacement contributes
    output wire [15:0] offset       // wrapped sum
);
    // zeroed, sign-extended or unchanged displacement
    wire [15:0] disp_ext;
    // full sum including the carry
    wire [17:0] sum_full;

    assign disp_ext = !disp_use ? 16'h0000 :
                      disp_wide ? disp_raw : {{8{disp_raw[7]}}, disp_raw[7:0]};
    assign sum_full = {2'h0, base_val} + {2'h0, index_val} + {2'h0, disp_ext};
    assign offset = sum_full[15:0];
endmodule

// ==== hdl/operand_address_generator.v ====
// operand, memory, port and interrupt-return address generation
`timescale 1ns/1ps
`include "oag_defs.vh"

// Overview of operation
// - addresses are segment base plus offset
// - default segment unless override prefix given, except for fetch and string destination
// - offset sums displacement, base and index
// - offset addition wraps modulo 65536
// - byte displacement sign extended to word
// - direct mode uses displacement only
// - register indirect uses register unchanged
// - based adds displacement to base register
// - indexed adds displacement to index register
// - based indexed adds base and index
// - based indexed displacement adds all three
// - register or immediate operands without memory
// - port space byte or word wide
// - port from 8-bit field or pointer
// - byte port address zero extended
// - interrupt pushes code segment, pointer, status
// - software and exception interrupts accepted, hardware only when non-maskable or enabled
// - signed operands two's complement, ordinals binary
// - packed decimal two digits per byte
// - default segment chosen by reference kind
module operand_address_generator (
    input  wire        clk,                    // core clock
    input  wire        rst,                    // synchronous reset, high
    // request from the decoder
    input  wire        req_valid,              // request strobe
    output wire        req_ready,              // accepting requests
    input  wire [2:0]  req_kind,               // fetch, data, stack, string, io, int
    input  wire [2:0]  addr_mode,              // addressing mode
    input  wire        base_sel,               // general base or base pointer
    input  wire        index_sel,              // source or destination index
    input  wire [15:0] displacement,           // displacement or immediate
    input  wire        disp_wide,              // displacement is 16 bits
    input  wire        seg_override,           // override prefix present
    input  wire [1:0]  seg_override_sel,       // override segment code
    input  wire        operand_wide,           // word operand
    input  wire        operand_signed,         // integer rather than ordinal
    input  wire        operand_packed,         // packed decimal operand
    input  wire [15:0] reg_operand,            // general register value
    input  wire        io_use_pointer,         // port from pointer register
    input  wire [16:0] string_len,             // string length in bytes
    input  wire [1:0]  int_source,             // interrupt source class
    input  wire        int_nmi,                // hardware request non-maskable
    input  wire        int_enable,             // maskable requests allowed
    input  wire [15:0] int_vector_cs,          // new code segment
    input  wire [15:0] int_vector_ip,          // new instruction pointer
    // register file values
    input  wire [15:0] general_base_register,  // general base
    input  wire [15:0] base_pointer,           // base pointer
    input  wire [15:0] source_index,           // source index
    input  wire [15:0] destination_index,      // destination index
    input  wire [15:0] port_pointer_register,  // port pointer
    input  wire [15:0] instruction_pointer,    // current pointer
    input  wire [15:0] status_word,            // flags
    input  wire [15:0] stack_pointer,          // stack pointer
    input  wire [15:0] code_segment,           // segment registers
    input  wire [15:0] stack_segment,
    input  wire [15:0] data_segment,
    input  wire [15:0] extra_segment,
    // answer to the bus interface unit
    output reg         out_valid,              // one-cycle result strobe
    output reg         out_is_mem,             // memory access
    output reg         out_is_io,              // port access
    output reg         out_is_write,           // stack push write
    output reg  [15:0] out_segment,            // segment base
    output reg  [15:0] out_offset,             // offset
    output reg  [19:0] out_phys,               // physical address
    output reg  [15:0] out_data,               // operand or push data
    output reg  [31:0] out_operand_ext,        // operand extended to 32 bits
    output reg         io_word,                // word-wide port
    output reg         io_reserved,            // port in reserved window
    output reg         str_len_err,            // string length out of range
    output reg         int_taken,              // interrupt accepted pulse
    output reg         int_done,               // new location loaded pulse
    output reg  [15:0] new_cs,                 // resumed code segment
    output reg  [15:0] new_ip                  // resumed pointer
);
    // ****************************************************
    // functions
    // ****************************************************

    // physical address from segment and offset
    function [19:0] phys_addr;
        input [15:0] seg;
        input [15:0] off;
        begin
            phys_addr = {seg, 4'h0} + {4'h0, off};
        end
    endfunction

    // segment register value from a code
    function [15:0] seg_value;
        input [1:0]  code;
        input [15:0] es_v;
        input [15:0] cs_v;
        input [15:0] ss_v;
        input [15:0] ds_v;
        begin
            case (code)
                `SEG_ES: seg_value = es_v;
                `SEG_CS: seg_value = cs_v;
                `SEG_SS: seg_value = ss_v;
                default: seg_value = ds_v;
            endcase
        end
    endfunction

    // ****************************************************
    // state
    // ****************************************************

    localparam ST_IDLE  = 2'h0;  // accepting requests
    localparam ST_PUSH  = 2'h1;  // pushing return context
    localparam ST_JUMP  = 2'h2;  // loading new location

    reg  [1:0]  state_q;         // control state
    reg  [1:0]  state_d;
    reg  [1:0]  push_cnt_q;      // pushes done
    reg  [1:0]  push_cnt_d;
    reg  [15:0] sp_q;            // working stack pointer
    reg  [15:0] sp_d;
    reg  [15:0] sav_cs_q;        // captured code segment
    reg  [15:0] sav_ip_q;        // captured pointer
    reg  [15:0] sav_sw_q;        // captured status word
    reg  [15:0] sav_ss_q;        // captured stack segment
    reg  [15:0] vec_cs_q;        // captured target segment
    reg  [15:0] vec_ip_q;        // captured target pointer

    // ****************************************************
    // offset selection
    // ****************************************************

    reg  [15:0] base_term;       // base contribution
    reg  [15:0] index_term;      // index contribution
    reg         disp_use;        // displacement contribution
    wire [15:0] ea_offset;       // effective offset
    reg  [1:0]  def_seg;         // default segment code
    wire [1:0]  seg_code;        // chosen segment code
    wire [15:0] seg_base;        // chosen segment value
    wire [15:0] port_addr;       // port address
    wire        mem_mode;        // mode reaches memory

    // terms per addressing mode
    always @* begin
        base_term  = 16'h0000;
        index_term = 16'h0000;
        disp_use   = 1'b0;
        case (addr_mode)
            `AM_DIRECT: begin
                disp_use = 1'b1;
            end
            `AM_REG_IND: begin
                if (disp_wide)
                    index_term = (index_sel == `IDX_DI) ? destination_index : source_index;
                else
                    base_term = (base_sel == `BASE_BP) ? base_pointer : general_base_register;
            end
            `AM_BASED: begin
                base_term = (base_sel == `BASE_BP) ? base_pointer : general_base_register;
                disp_use  = 1'b1;
            end
            `AM_INDEXED: begin
                index_term = (index_sel == `IDX_DI) ? destination_index : source_index;
                disp_use   = 1'b1;
            end
            `AM_BASED_IDX: begin
                base_term  = (base_sel == `BASE_BP) ? base_pointer : general_base_register;
                index_term = (index_sel == `IDX_DI) ? destination_index : source_index;
            end
            `AM_BIDX_DISP: begin
                base_term  = (base_sel == `BASE_BP) ? base_pointer : general_base_register;
                index_term = (index_sel == `IDX_DI) ? destination_index : source_index;
                disp_use   = 1'b1;
            end
            default: begin
                disp_use = 1'b0;
            end
        endcase
    end

    offset_adder u_adder (
        .base_val  (base_term),
        .index_val (index_term),
        .disp_raw  (displacement),
        .disp_wide (disp_wide),
        .disp_use  (disp_use),
        .offset    (ea_offset)
    );

    assign mem_mode = (addr_mode != `AM_REG) && (addr_mode != `AM_IMM);

    // default segment per reference kind
    always @* begin
        case (req_kind)
            `KIND_FETCH:  def_seg = `SEG_CS;
            `KIND_STACK:  def_seg = `SEG_SS;
            `KIND_STRING: def_seg = (index_sel == `IDX_DI) ? `SEG_ES : `SEG_DS;
            default: begin
                if (addr_mode != `AM_DIRECT && addr_mode != `AM_INDEXED &&
                    base_sel == `BASE_BP && base_term == base_pointer &&
                    addr_mode != `AM_REG_IND)
                    def_seg = `SEG_SS;
                else if (addr_mode == `AM_REG_IND && !disp_wide && base_sel == `BASE_BP)
                    def_seg = `SEG_SS;
                else
                    def_seg = `SEG_DS;
            end
        endcase
    end

    assign seg_code = (seg_override && req_kind != `KIND_FETCH &&
                       !(req_kind == `KIND_STRING && index_sel == `IDX_DI)) ?
                      seg_override_sel : def_seg;
    assign seg_base = seg_value(seg_code, extra_segment, code_segment,
                                stack_segment, data_segment);

    assign port_addr = io_use_pointer ? port_pointer_register : {8'h00, displacement[7:0]};

    assign req_ready = (state_q == ST_IDLE);

    // ****************************************************
    // control state machine
    // ****************************************************

    // next state and stack pointer
    always @* begin
        state_d    = state_q;
        push_cnt_d = push_cnt_q;
        sp_d       = sp_q;
        case (state_q)
            ST_IDLE: begin
                if (req_valid && req_kind == `KIND_INT &&
                    (int_source != `INT_SRC_HW || int_nmi || int_enable)) begin
                    state_d    = ST_PUSH;
                    push_cnt_d = 2'h0;
                    sp_d       = stack_pointer;
                end
            end
            ST_PUSH: begin
                sp_d       = sp_q - 16'h0002;
                push_cnt_d = push_cnt_q + 2'h1;
                if (push_cnt_q == `INT_PUSHES - 2'h1)
                    state_d = ST_JUMP;
            end
            ST_JUMP: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // state registers and captured context
    always @(posedge clk) begin
        if (rst) begin
            state_q    <= ST_IDLE;
            push_cnt_q <= 2'h0;
            sp_q       <= 16'h0000;
            sav_cs_q   <= 16'h0000;
            sav_ip_q   <= 16'h0000;
            sav_sw_q   <= 16'h0000;
            sav_ss_q   <= 16'h0000;
            vec_cs_q   <= 16'h0000;
            vec_ip_q   <= 16'h0000;
        end else begin
            state_q    <= state_d;
            push_cnt_q <= push_cnt_d;
            sp_q       <= sp_d;
            // capture context on acceptance
            if (state_q == ST_IDLE && state_d == ST_PUSH) begin
                sav_cs_q <= code_segment;
                sav_ip_q <= instruction_pointer;
                sav_sw_q <= status_word;
                sav_ss_q <= stack_segment;
                vec_cs_q <= int_vector_cs;
                vec_ip_q <= int_vector_ip;
            end
        end
    end

    // ****************************************************
    // output registers
    // ****************************************************

    // registered answer
    always @(posedge clk) begin
        if (rst) begin
            out_valid       <= 1'b0;
            out_is_mem      <= 1'b0;
            out_is_io       <= 1'b0;
            out_is_write    <= 1'b0;
            out_segment     <= 16'h0000;
            out_offset      <= 16'h0000;
            out_phys        <= 20'h00000;
            out_data        <= 16'h0000;
            out_operand_ext <= 32'h00000000;
            io_word         <= 1'b0;
            io_reserved     <= 1'b0;
            str_len_err     <= 1'b0;
            int_taken       <= 1'b0;
            int_done        <= 1'b0;
            new_cs          <= 16'h0000;
            new_ip          <= 16'h0000;
        end else begin
            out_valid    <= 1'b0;
            out_is_write <= 1'b0;
            int_taken    <= 1'b0;
            int_done     <= 1'b0;
            if (state_q == ST_IDLE && req_valid) begin
                if (req_kind == `KIND_IO) begin
                    out_valid   <= 1'b1;
                    out_is_mem  <= 1'b0;
                    out_is_io   <= 1'b1;
                    out_segment <= 16'h0000;
                    out_offset  <= port_addr;
                    out_phys    <= {4'h0, port_addr};
                    io_word     <= operand_wide;
                    io_reserved <= (port_addr >= `IO_RSV_LO) && (port_addr <= `IO_RSV_HI);
                end else if (req_kind == `KIND_INT) begin
                    // accepted only when not masked
                    int_taken <= (state_d == ST_PUSH);
                end else if (mem_mode) begin
                    out_valid   <= 1'b1;
                    out_is_mem  <= 1'b1;
                    out_is_io   <= 1'b0;
                    out_segment <= seg_base;
                    out_offset  <= ea_offset;
                    out_phys    <= phys_addr(seg_base, ea_offset);
                    str_len_err <= (req_kind == `KIND_STRING) &&
                                   ((string_len == 17'h00000) ||
                                    (string_len > `STR_MAX_BYTES));
                end else begin
                    out_valid  <= 1'b1;
                    out_is_mem <= 1'b0;
                    out_is_io  <= 1'b0;
                    out_data   <= (addr_mode == `AM_IMM) ? displacement : reg_operand;
                    if (operand_packed)
                        out_operand_ext <= {24'h000000, out_data_digits(reg_operand[7:0])};
                    else if (operand_wide)
                        out_operand_ext <= {{16{operand_signed &
                                              ((addr_mode == `AM_IMM) ? displacement[15]
                                                                       : reg_operand[15])}},
                                            (addr_mode == `AM_IMM) ? displacement : reg_operand};
                    else
                        out_operand_ext <= {{24{operand_signed &
                                              ((addr_mode == `AM_IMM) ? displacement[7]
                                                                       : reg_operand[7])}},
                                            (addr_mode == `AM_IMM) ? displacement[7:0]
                                                                   : reg_operand[7:0]};
                end
            end else if (state_q == ST_PUSH) begin
                out_valid    <= 1'b1;
                out_is_mem   <= 1'b1;
                out_is_io    <= 1'b0;
                out_is_write <= 1'b1;
                out_segment  <= sav_ss_q;
                out_offset   <= sp_q - 16'h0002;
                out_phys     <= phys_addr(sav_ss_q, sp_q - 16'h0002);
                case (push_cnt_q)
                    2'h0:    out_data <= sav_cs_q;
                    2'h1:    out_data <= sav_ip_q;
                    default: out_data <= sav_sw_q;
                endcase
            end else if (state_q == ST_JUMP) begin
                int_done <= 1'b1;
                new_cs   <= vec_cs_q;
                new_ip   <= vec_ip_q;
            end
        end
    end

    // packed digit check: valid nibble kept, invalid digit forced to zero
    function [7:0] out_data_digits;
        input [7:0] b;
        begin
            out_data_digits = {(b[7:4] > 4'h9) ? 4'h0 : b[7:4],
                               (b[3:0] > 4'h9) ? 4'h0 : b[3:0]};
        end
    endfunction
endmodule

// ==== testbench/oag_asserts.sv ====
// port checker for the operand address generator
`timescale 1ns/1ps
`include "oag_defs.vh"
module oag_asserts (
    input wire        clk,
    input wire        rst,
    input wire        req_valid,
    input wire        req_ready,
    input wire [2:0]  req_kind,
    input wire [2:0]  addr_mode,
    input wire [15:0] displacement,
    input wire        disp_wide,
    input wire        io_use_pointer,
    input wire [15:0] port_pointer_register,
    input wire        out_valid,
    input wire        out_is_mem,
    input wire        out_is_io,
    input wire        out_is_write,
    input wire [15:0] out_segment,
    input wire [15:0] out_offset,
    input wire [19:0] out_phys,
    input wire        int_taken,
    input wire        int_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // accepted request and its flavours
    wire        take = req_valid && req_ready;
    wire        dir  = take && req_kind == `KIND_DATA && addr_mode == `AM_DIRECT;
    wire        port = take && req_kind == `KIND_IO;
    wire [15:0] sx   = {{8{displacement[7]}}, displacement[7:0]};
    a_answer_next: assert property (take && req_kind != `KIND_INT |=> out_valid)
        else $error("no answer");
    a_phys_sum: assert property (out_valid && out_is_mem |->
        out_phys == {out_segment, 4'h0} + {4'h0, out_offset})
        else $error("bad physical address");
    a_push_train: assert property (int_taken |=>
        (out_valid && out_is_write)[*3] ##1 int_done)
        else $error("push train broken");
    a_busy_refuse: assert property (int_taken |-> !req_ready[*4])
        else $error("ready during pushes");
    a_port_zext: assert property (port && !io_use_pointer |=>
        out_is_io && out_offset[15:8] == 8'h00)
        else $error("byte port not zero extended");
    a_port_ptr: assert property (port && io_use_pointer |=>
        out_offset == $past(port_pointer_register))
        else $error("pointer port address wrong");
    a_direct_wide: assert property (dir && disp_wide |=>
        out_offset == $past(displacement))
        else $error("direct word offset wrong");
    a_direct_sext: assert property (dir && !disp_wide |=> out_offset == $past(sx))
        else $error("byte offset not sign extended");
    c_interrupt: cover property (int_done);
    c_port_byte: cover property (port && !io_use_pointer);
    c_narrow: cover property (dir && !disp_wide);
endmodule
bind operand_address_generator oag_asserts chk_i (.*);

// ==== testbench/biu_model.sv ====
// bus side model counting stack push writes
`timescale 1ns/1ps
module biu_model (
    input  wire       clk,
    input  wire       rst,
    input  wire       int_taken,
    input  wire       out_valid,
    input  wire       out_is_write,
    output reg  [1:0] push_count
);
    always @(posedge clk) begin
        if (rst || int_taken) begin
            push_count <= 2'h0;
        end else if (out_valid && out_is_write) begin
            push_count <= push_count + 2'h1;
        end
    end
endmodule

// ==== testbench/operand_address_generator_tb.sv ====
// random and corner testbench for the address generator
`timescale 1ns/1ps
`include "oag_defs.vh"
module operand_address_generator_tb;
    reg        clk, rst, req_valid, base_sel, index_sel, disp_wide, seg_override;
    reg        io_use_pointer, int_nmi, int_enable;
    reg [2:0]  req_kind, addr_mode;
    reg [1:0]  seg_override_sel, int_source;
    reg [15:0] displacement, reg_operand, int_vector_cs, int_vector_ip;
    reg [15:0] general_base_register, base_pointer, source_index, destination_index;
    reg [15:0] port_pointer_register, instruction_pointer, status_word, stack_pointer;
    reg [15:0] code_segment, stack_segment, data_segment, extra_segment, p;
    reg [31:0] seed;
    wire       req_ready, out_valid, out_is_io, out_is_write, io_reserved, int_taken, int_done;
    wire [15:0] out_segment, out_offset, out_data, new_cs, new_ip;
    wire [1:0] push_count;
    integer    errors, n_checks, i, j;
    operand_address_generator uut (.operand_wide(1'b0), .operand_signed(1'b0),
        .operand_packed(1'b0), .string_len(17'h00010), .out_is_mem(), .out_phys(),
        .out_operand_ext(), .io_word(), .str_len_err(), .*);
    biu_model biu (.*);
    // clock of 10 ns
    always #5 clk = ~clk;
    // xorshift step on the seed
    function [31:0] r();
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            r = seed;
        end
    endfunction
    // fresh random inputs
    task roll;
        begin
            {general_base_register, base_pointer} = r();
            {source_index, destination_index} = r();
            {displacement, port_pointer_register} = r();
            {code_segment, stack_segment} = r();
            {data_segment, extra_segment} = r();
            {instruction_pointer, status_word} = r();
            {stack_pointer, reg_operand} = r();
            {int_vector_cs, int_vector_ip} = r();
            {io_use_pointer, base_sel, index_sel, disp_wide, seg_override, seg_override_sel} = r();
        end
    endtask
    // expected offset
    function [15:0] eoff();
        reg [15:0] sx, b, x;
        begin
            sx = disp_wide ? displacement : {{8{displacement[7]}}, displacement[7:0]};
            b = base_sel ? base_pointer : general_base_register;
            x = index_sel ? destination_index : source_index;
            case (addr_mode)
                `AM_DIRECT: eoff = sx;
                `AM_REG_IND: eoff = disp_wide ? x : b;
                `AM_BASED: eoff = b + sx;
                `AM_INDEXED: eoff = x + sx;
                `AM_BASED_IDX: eoff = b + x;
                default: eoff = b + x + sx;
            endcase
        end
    endfunction
    // expected segment base
    function [15:0] eseg();
        reg       ub;
        reg [1:0] c;
        begin
            ub = addr_mode == `AM_BASED || addr_mode >= `AM_BASED_IDX
                || (addr_mode == `AM_REG_IND && !disp_wide);
            c = seg_override ? seg_override_sel : (ub && base_sel) ? `SEG_SS : `SEG_DS;
            case (c)
                `SEG_ES: eseg = extra_segment;
                `SEG_CS: eseg = code_segment;
                `SEG_SS: eseg = stack_segment;
                default: eseg = data_segment;
            endcase
        end
    endfunction
    task chk(input [31:0] seen, input [31:0] exp, input [8*8-1:0] what);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("BAD %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // one request, returns just after the edge that takes it
    task go;
        begin
            @(posedge clk);
            #1 req_valid = 1'b1;
            @(posedge clk);
            #1 req_valid = 1'b0;
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d errors %0d", n_checks, errors);
            if (errors == 0 && n_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // hang guard
    initial begin
        #500000;
        errors = errors + 1;
        end_sim;
    end
    initial begin
        {clk, rst, req_valid, int_nmi, int_enable, int_source} = 6'h10;
        {req_kind, addr_mode, errors, n_checks, seed} = {6'h00, 32'd0, 32'd0, 32'd71};
        roll;
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        // memory modes with random registers
        for (i = 0; i < 60; i = i + 1) begin
            roll;
            req_kind = `KIND_DATA;
            addr_mode = 3'(i % 6 + 2);
            go;
            chk(out_offset, eoff(), "offset");
            chk(out_segment, eseg(), "segment");
        end
        // register and immediate operands
        for (i = 0; i < 2; i = i + 1) begin
            roll;
            addr_mode = 3'(i);
            go;
            chk(out_data, i ? displacement : reg_operand, "operand");
        end
        roll;
        seg_override = 1'b1;
        req_kind = `KIND_FETCH;
        addr_mode = `AM_DIRECT;
        go;
        chk(out_segment, code_segment, "fetchseg");
        // ports, reserved edges first
        for (i = 0; i < 20; i = i + 1) begin
            roll;
            req_kind = `KIND_IO;
            if (i < 4) {io_use_pointer, displacement[7:0]} = {1'b0, 8'hf6 + 8'(i * 3)};
            p = io_use_pointer ? port_pointer_register : {8'h00, displacement[7:0]};
            go;
            chk(out_offset, p, "port");
            chk(io_reserved, p >= 16'h00f8 && p <= 16'h00ff, "reserved");
            chk(out_is_io, 1'b1, "isio");
        end
        // every interrupt source as non-maskable, then a masked hardware request refused
        for (i = 0; i < 4; i = i + 1) begin
            roll;
            {req_kind, int_source, int_nmi} = {`KIND_INT, 2'(i % 3), i < 3};
            go;
            chk(int_taken, i < 3, "taken");
            chk(req_ready, i == 3, "ready");
            for (j = 0; j < 3 && i < 3; j = j + 1) begin
                @(posedge clk);
                #1;
                p = j == 0 ? code_segment : j == 1 ? instruction_pointer : status_word;
                chk(out_data, p, "pushdata");
                chk(out_offset, stack_pointer - 16'(2 * j + 2), "pushoff");
                chk(out_segment, stack_segment, "pushseg");
            end
            if (i < 3) begin
                @(posedge clk);
                #1;
                chk(int_done, 1'b1, "resume");
                chk({new_cs, new_ip}, {int_vector_cs, int_vector_ip}, "newloc");
                chk(push_count, 2'h3, "pushes");
            end
        end
        end_sim;
    end
endmodule
